// >>> hdl/deser_pkg.sv
// Shared types and constants for the input deserializer.
package deser_pkg;
   typedef enum logic [2:0] {
      MODE_MEMORY,
      MODE_NETWORKING,
      MODE_OVERSAMPLE,
      MODE_QUAD_RATE_MEMORY_MODEL,
      MODE_THIRD_GEN_MEMORY_MODEL
   } mode_t;
   typedef enum logic [1:0] {
      ROUTE_NONE,
      ROUTE_DELAY_UNREGISTERED_ONLY,
      ROUTE_DELAY_REGISTERED_ONLY,
      ROUTE_BOTH
   } route_t;
   typedef struct packed {
      logic [14:0] rsvd;
      logic soft_rst;
      logic [3:0] sample_reg_reset_value;
      route_t delay_routing_setting;
      logic loopback_select;
      logic slave;
      logic [3:0] width;
      logic ddr;
      mode_t mode;
   } cfg_t;
   localparam logic [31:0] CFG_RESET = 32'h0000F048;
   localparam logic [3:0] SAMPLE_RESET = 4'hF;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_WORD = 8'h08;
   localparam int STAT_SUSPECT = 0;
   localparam int STAT_ILLEGAL = 1;
   localparam int PIN_PAD = 0;
   localparam int PIN_DLY = 4;
   localparam int PIN_FB = 8;
   localparam int PIN_INV = 12;
   localparam int PIN_W = 14;
   localparam logic [3:0] W_TWO = 4'h2;
   localparam logic [3:0] W_FOUR = 4'h4;
   localparam logic [3:0] W_SIX = 4'h6;
   localparam logic [3:0] W_EIGHT = 4'h8;
   localparam logic [3:0] W_TEN = 4'hA;
   localparam logic [3:0] W_FOURTEEN = 4'hE;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;
   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] ok;
   } sync_t;
endpackage

// >>> hdl/input_deserializer.sv
// Serial-to-parallel input converter with AXI4-Lite configuration.
// Summary of operation
// (RQ1) Networking mode: serial and word clocks stay aligned, never inverted.
// (RQ2) Memory mode: capture clock and word clock are kept phase aligned.
// (RQ3) Memory mode: user calibrates the serial-to-capture clock transfer.
// (RQ4) Oversample: capture both edges of two clocks, output in fast domain.
// (RQ5) Oversample ignores the word clock; four phases 0, 90, 180, 270.
// (RQ6) Master/slave pair widens words to 10 or 14, double rate only.
// (RQ7) User wires master cascade outputs to adjacent slave cascade inputs.
// (RQ8) A slave presents its bits only on parallel outputs 3 to 8.
// (RQ9) At width 10 slave outputs 3 and 4 hold the last two bits.
// (RQ10) Cascading needs networking mode and one master, one slave role.
// (RQ11) Master and slave are given the same word width.
// (RQ12) Memory mode capture stage adds one word-clock cycle of latency.
// (RQ13) Networking and tool-only memory modes have two word cycles latency.
// (RQ14) Polarity flips only in tool modes; output suspect until reset.
// (RQ15) Loopback takes serial input from the output serializer feedback.
// (RQ16) User sets serializer and converter to identical rate and width.
// (RQ17) Loopback with cascading: master serializer feeds master converter.
// (RQ18) Delay routing picks direct or delayed input per output path.
// (RQ19) Rate selects single or double rate sampling; double is default.
// (RQ20) Legal widths: 2-8 single rate, 4,6,8,10,14 double rate.
// (RQ21) The four sample registers load a configurable reset value, default 1.
// (RQ22) Parallel outputs update on the word tick after the mode's latency.
`timescale 1ns/10ps
module input_deserializer (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire deser_pkg::axi_req_t axi_req,
   output deser_pkg::axi_rsp_t axi_rsp,
   input wire logic [3:0] pad_samples,
   input wire logic [3:0] delayed_pad_input,
   input wire logic [3:0] loopback_feed,
   input wire logic fast_clock_invert_select,
   input wire logic word_clock_invert_select,
   input wire logic [5:0] cascade_input,
   output logic [5:0] cascade_output,
   output logic [7:0] parallel_out,
   output logic parallel_strobe,
   output logic direct_out
);
   import deser_pkg::*;

   typedef struct packed {
      axi_rsp_t rsp;
      logic aw_held;
      logic w_held;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      cfg_t cfg;
      sync_t sync;
      logic [1:0] inv_seen;
      logic [3:0] sample;
      logic [15:0] sreg;
      logic [4:0] cnt;
      logic [7:0] stage_a;
      logic [7:0] stage_b;
      logic [7:0] q;
      logic strobe;
      logic direct;
      logic [5:0] casc;
      logic suspect;
   } state_t;

   state_t st;
   state_t next_st;
   logic [PIN_W-1:0] pins;
   logic tool_mode;
   logic width_ok;
   logic illegal;
   logic done;
   logic reg_dly;
   logic unreg_dly;

   assign pins = {word_clock_invert_select, fast_clock_invert_select,
                  loopback_feed, delayed_pad_input, pad_samples};
   assign tool_mode = st.cfg.mode inside {MODE_QUAD_RATE_MEMORY_MODEL,
                                          MODE_THIRD_GEN_MEMORY_MODEL};
   assign reg_dly = st.cfg.delay_routing_setting inside
                    {ROUTE_DELAY_REGISTERED_ONLY, ROUTE_BOTH};
   assign unreg_dly = st.cfg.delay_routing_setting inside
                      {ROUTE_DELAY_UNREGISTERED_ONLY, ROUTE_BOTH};

   // A slave only makes sense above eight bits and at double rate.
   assign width_ok = st.cfg.ddr ? // [RQ6] [RQ20]
      (st.cfg.width inside {W_FOUR, W_SIX, W_EIGHT, W_TEN, W_FOURTEEN}) &&
      (!st.cfg.slave || st.cfg.width > W_EIGHT) :
      (st.cfg.width >= W_TWO && st.cfg.width <= W_EIGHT && !st.cfg.slave);

   // Memory-style modes run at double rate with four-bit words only.
   assign illegal = (st.cfg.mode == MODE_NETWORKING) ? !width_ok : // [RQ10]
      (st.cfg.mode == MODE_OVERSAMPLE) ? st.cfg.slave :
      (st.cfg.mode == MODE_MEMORY || tool_mode) ?
      (!st.cfg.ddr || st.cfg.width != W_FOUR || st.cfg.slave) : 1'b1;

   // Word tick: the shift register holds a whole word of the set width.
   assign done = !illegal && st.cfg.mode != MODE_OVERSAMPLE &&
                 st.cnt >= {1'b0, st.cfg.width}; // [RQ11] [RQ22]

   always_comb begin
      logic [3:0] src;
      logic [7:0] word;
      logic [7:0] slv;
      logic [4:0] step;
      logic [31:0] wmerge;
      src = '0;
      word = '0;
      slv = {cascade_input, 2'b00};
      step = '0;
      wmerge = '0;
      next_st = st;

      // Four flops per pin; a change counts once stages two and three agree.
      next_st.sync.s1 = pins;
      next_st.sync.s2 = st.sync.s1;
      next_st.sync.s3 = st.sync.s2;
      next_st.sync.ok = (~(st.sync.s2 ^ st.sync.s3) & st.sync.s3) |
                        ((st.sync.s2 ^ st.sync.s3) & st.sync.ok);

      // Loopback overrides the pad, so external data is not seen then.
      if (st.cfg.loopback_select) begin
         src = st.sync.ok[PIN_FB +: 4]; // [RQ15]
         next_st.direct = st.sync.ok[PIN_FB];
      end else begin
         src = reg_dly ? st.sync.ok[PIN_DLY +: 4] // [RQ18]
                       : st.sync.ok[PIN_PAD +: 4];
         next_st.direct = unreg_dly ? st.sync.ok[PIN_DLY]
                                    : st.sync.ok[PIN_PAD];
      end
      // In the tool-only modes an inverted fast clock swaps the 0 and 180 degree phase pairs.
      if (tool_mode && st.sync.ok[PIN_INV]) begin
         src = {src[1:0], src[3:2]}; // [RQ14]
      end
      // Samples: bit0 = 0 deg, bit1 = 90, bit2 = 180, bit3 = 270.
      next_st.sample = src; // [RQ4] [RQ5]

      if (st.cfg.ddr) begin
         next_st.sreg = {st.sreg[13:0], st.sample[0], st.sample[2]}; // [RQ19]
         step = 5'h02;
      end else begin
         next_st.sreg = {st.sreg[14:0], st.sample[0]}; // [RQ19]
         step = 5'h01;
      end
      // Bits 8 to 13 leave the master towards an adjacent slave.
      next_st.casc = next_st.sreg[13:8]; // [RQ6]

      for (int k = 0; k < 8; k++) begin
         if (st.cfg.slave) begin
            word[k] = (k < int'(st.cfg.width) - 6) ?
                      slv[k] : 1'b0; // [RQ8] [RQ9]
         end else begin
            word[k] = (k < int'(st.cfg.width)) ? st.sreg[k] : 1'b0;
         end
      end

      next_st.strobe = 1'b0;
      if (illegal || st.cfg.mode == MODE_OVERSAMPLE) begin
         next_st.cnt = '0;
      end else if (done) begin
         next_st.cnt = st.cnt - {1'b0, st.cfg.width} + step;
      end else begin
         next_st.cnt = st.cnt + step;
      end

      if (done) begin
         next_st.stage_a = word;
         next_st.stage_b = st.stage_a;
         next_st.strobe = 1'b1; // [RQ22]
         if (st.cfg.mode == MODE_MEMORY) begin
            next_st.q = st.stage_a; // [RQ12]
         end else begin
            next_st.q = st.stage_b; // [RQ13]
         end
      end
      // Oversampling bypasses the word clock: four samples every cycle.
      if (st.cfg.mode == MODE_OVERSAMPLE) begin
         next_st.q = {4'h0, st.sample}; // [RQ5]
         next_st.strobe = 1'b1;
      end

      // Soft reset is handled before the flag set so a flip is never lost.
      if (st.cfg.soft_rst) begin
         next_st.sample = st.cfg.sample_reg_reset_value; // [RQ21]
         next_st.cnt = '0;
         next_st.suspect = 1'b0;
         next_st.cfg.soft_rst = 1'b0;
      end
      next_st.inv_seen = st.sync.ok[PIN_INV +: 2];
      if (tool_mode && st.sync.ok[PIN_INV +: 2] != st.inv_seen) begin
         next_st.suspect = 1'b1; // [RQ14]
      end

      if (st.rsp.bvalid && axi_req.bready) begin
         next_st.rsp.bvalid = 1'b0;
      end
      if (st.rsp.rvalid && axi_req.rready) begin
         next_st.rsp.rvalid = 1'b0;
      end
      if (axi_req.awvalid && st.rsp.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && st.rsp.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = axi_req.wdata;
         next_st.w_strb = axi_req.wstrb;
      end
      if (next_st.aw_held && next_st.w_held && !next_st.rsp.bvalid) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.rsp.bvalid = 1'b1;
         next_st.rsp.bresp = RESP_OKAY;
         wmerge = next_st.cfg;
         for (int b = 0; b < 4; b++) begin
            if (next_st.w_strb[b]) begin
               wmerge[8*b +: 8] = next_st.w_data[8*b +: 8];
            end
         end
         case (next_st.aw_addr)
            OFS_CONFIG: begin
               next_st.cfg = cfg_t'(wmerge);
               next_st.cfg.rsvd = '0;
            end
            OFS_STATUS, OFS_WORD: begin
            end
            default: next_st.rsp.bresp = RESP_SLVERR;
         endcase
      end
      if (axi_req.arvalid && st.rsp.arready) begin
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rresp = RESP_OKAY;
         next_st.rsp.rdata = '0;
         case (axi_req.araddr)
            OFS_CONFIG: next_st.rsp.rdata = st.cfg;
            OFS_STATUS: begin
               next_st.rsp.rdata[STAT_SUSPECT] = st.suspect;
               next_st.rsp.rdata[STAT_ILLEGAL] = illegal;
            end
            OFS_WORD: next_st.rsp.rdata[7:0] = st.q;
            default: next_st.rsp.rresp = RESP_SLVERR;
         endcase
      end
      next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
      next_st.rsp.wready = !next_st.w_held && !next_st.rsp.bvalid;
      next_st.rsp.arready = !next_st.rsp.rvalid;
   end

   // The clock enable freezes everything, the bus slave included.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
         st.cfg <= cfg_t'(CFG_RESET);
         st.sample <= SAMPLE_RESET; // [RQ21]
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign axi_rsp = st.rsp;
   assign cascade_output = st.casc;
   assign parallel_out = st.q;
   assign parallel_strobe = st.strobe;
   assign direct_out = st.direct;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence mem_word;
      clk_en && done && st.cfg.mode == MODE_MEMORY;
   endsequence
   sequence net_word;
      clk_en && done && st.cfg.mode != MODE_MEMORY;
   endsequence
   sequence pol_flip;
      clk_en && tool_mode && st.sync.ok[PIN_INV +: 2] != st.inv_seen;
   endsequence

   chk_memory_latency: assert property ( // [RQ12]
      mem_word |=> parallel_strobe && parallel_out == $past(st.stage_a))
      else $error("memory word latency is not one word cycle");
   chk_network_latency: assert property ( // [RQ13]
      net_word |=> parallel_strobe && parallel_out == $past(st.stage_b))
      else $error("word latency is not two word cycles");
   chk_oversample_phases: assert property ( // [RQ5]
      clk_en && st.cfg.mode == MODE_OVERSAMPLE
      |=> parallel_strobe && parallel_out == {4'h0, $past(st.sample)})
      else $error("oversample phases not presented each cycle");
   chk_slave_lanes: assert property ( // [RQ8]
      clk_en && done && st.cfg.slave |=> st.stage_a[1:0] == 2'b00)
      else $error("slave drove outputs below lane three");
   chk_ten_bit_tail: assert property ( // [RQ9]
      clk_en && done && st.cfg.slave && st.cfg.width == W_TEN
      |=> st.stage_a[3:2] == $past(cascade_input[1:0]) &&
          st.stage_a[7:4] == 4'h0)
      else $error("width ten tail not on slave lanes three and four");
   chk_sample_reload: assert property ( // [RQ21]
      clk_en && st.cfg.soft_rst
      |=> st.sample == $past(st.cfg.sample_reg_reset_value))
      else $error("sample registers missed the reset value");
   chk_loopback_path: assert property ( // [RQ15]
      clk_en && st.cfg.loopback_select
      |=> direct_out == $past(st.sync.ok[PIN_FB]))
      else $error("loopback feed not selected");
   chk_route_unreg: assert property ( // [RQ18]
      clk_en && !st.cfg.loopback_select && unreg_dly
      |=> direct_out == $past(st.sync.ok[PIN_DLY]))
      else $error("unregistered path not taken from delayed input");
   chk_double_rate: assert property ( // [RQ19]
      clk_en && st.cfg.ddr
      |=> st.sreg[1:0] == {$past(st.sample[0]), $past(st.sample[2])})
      else $error("double rate shift lost an edge sample");
   chk_flip_flagged: assert property ( // [RQ14]
      pol_flip |=> st.suspect)
      else $error("polarity flip not flagged");

   chk_illegal_hold: assert property ( // [RQ20]
      clk_en && illegal |=> st.cnt == 5'h00)
      else $error("bit counter ran under an illegal setting");
   chk_strobe_pulse: assert property ( // [RQ22]
      clk_en && !done && st.cfg.mode != MODE_OVERSAMPLE |=> !parallel_strobe)
      else $error("word strobe outside a word tick");
   chk_route_direct: assert property ( // [RQ18]
      clk_en && !st.cfg.loopback_select && !unreg_dly
      |=> direct_out == $past(st.sync.ok[PIN_PAD]))
      else $error("unregistered path not taken from the pad");
   chk_route_reg: assert property ( // [RQ18]
      clk_en && !st.cfg.loopback_select && reg_dly && !tool_mode &&
      !st.cfg.soft_rst |=> st.sample == $past(st.sync.ok[PIN_DLY +: 4]))
      else $error("registered path not taken from delayed input");
   chk_single_rate: assert property ( // [RQ19]
      clk_en && !st.cfg.ddr
      |=> st.sreg[1:0] == {$past(st.sreg[0]), $past(st.sample[0])})
      else $error("single rate shift took other than one bit");
   chk_cascade_bits: assert property ( // [RQ6]
      clk_en |=> cascade_output == st.sreg[13:8])
      else $error("cascade output out of step with the shift register");
   chk_flip_ignored: assert property ( // [RQ14]
      clk_en && !tool_mode && !st.suspect |=> !st.suspect)
      else $error("polarity flip flagged outside the tool-only modes");
   // The swap is checked on the pad path so the routing cannot mask it.
   chk_phase_swap: assert property ( // [RQ14]
      clk_en && tool_mode && st.sync.ok[PIN_INV] &&
      !st.cfg.loopback_select && !reg_dly && !st.cfg.soft_rst
      |=> st.sample == {$past(st.sync.ok[PIN_PAD +: 2]),
                        $past(st.sync.ok[PIN_PAD + 2 +: 2])})
      else $error("inverted fast clock did not swap phase pairs");
endmodule

// >>> dv/serial_source.sv
// Behavioural serial source for the pad, delayed and loopback lines.
`timescale 1ns/10ps
module serial_source (
   input wire logic mclk,
   input wire logic [11:0] pattern,
   output logic [3:0] pad_samples,
   output logic [3:0] delayed_pad_input,
   output logic [3:0] loopback_feed
);
   // Each line repeats its four phase samples every cycle, so a word of any
   // width carries one repeating bit pair and its alignment cannot matter.
   // One clock stands for every capture clock, which keeps them aligned.
   always @(posedge mclk) begin
      pad_samples <= pattern[3:0];
      delayed_pad_input <= pattern[7:4];
      loopback_feed <= pattern[11:8];
   end
endmodule

// >>> dv/input_deserializer_tb.sv
// Self-checking bench for the input deserializer.
`timescale 1ns/10ps
module input_deserializer_tb;
   import deser_pkg::*;
   logic mclk = 0, sys_rst = 1, fcis = 0, wcis = 0, ce = 1;
   axi_req_t req = '0;
   axi_rsp_t rsp;
   logic [11:0] pat = '0;
   logic [5:0] casc = '0;
   logic [3:0] pad, dly, fb, v;
   logic [5:0] cout;
   logic [7:0] pout;
   logic stb, dout;
   logic [31:0] rd;
   logic [1:0] rs;
   int fail_count = 0, tests_run = 0, n, nm, nn;
   serial_source u_serial_source(.mclk(mclk), .pattern(pat),
      .pad_samples(pad), .delayed_pad_input(dly), .loopback_feed(fb));
   input_deserializer u_input_deserializer(.mclk(mclk),
      .sys_rst(sys_rst), .clk_en(ce), .axi_req(req), .axi_rsp(rsp),
      .pad_samples(pad), .delayed_pad_input(dly), .loopback_feed(fb),
      .fast_clock_invert_select(fcis), .word_clock_invert_select(wcis),
      .cascade_input(casc), .cascade_output(cout), .parallel_out(pout),
      .parallel_strobe(stb), .direct_out(dout));
   initial begin
      forever #20 mclk = ~mclk;
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One transfer at a time; each channel is released when it is taken.
   task automatic axi(bit wr, logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= wr;
      req.arvalid <= !wr;
      req.rready <= !wr;
      forever begin
         @(posedge mclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.arready) req.arvalid <= 1'b0;
         if (req.bready && rsp.bvalid || req.rready && rsp.rvalid) begin
            req.bready <= 1'b0;
            req.rready <= 1'b0;
            rd = rsp.rdata;
            rs = wr ? rsp.bresp : rsp.rresp;
            break;
         end
      end
   endtask
   // Fields: {route, loopback, slave}; sample reset value left at 4'hF.
   function automatic logic [31:0] cfg(logic [2:0] m, logic dr,
         logic [3:0] w, logic [3:0] x);
      return {16'h0000, 4'hF, x, w, dr, m};
   endfunction
   // Newest bit sits in bit 0; phase 0 is the older bit of a pair.
   function automatic logic [3:0] wexp(logic [3:0] v, logic dr);
      return dr ? {v[0], v[2], v[0], v[2]} : {4{v[0]}};
   endfunction
   function automatic logic ok_w(logic dr, logic [3:0] w);
      return dr ? (w inside {4, 6, 8, 10, 14}) : (w >= 2 && w <= 8);
   endfunction
   task automatic wait_stb();
      repeat (64) begin
         @(posedge mclk);
         if (stb === 1'b1) return;
      end
      chk("strobe seen", 1, 0);
   endtask
   task automatic setw(logic [31:0] c);
      axi(1, OFS_CONFIG, c);
      // Eight ticks cover the synchroniser, the shift and both word stages.
      repeat (8) wait_stb();
   endtask
   // Counts word ticks from a data change until the new word shows.
   task automatic lat(logic [2:0] m, output int k);
      pat <= 12'h001;
      setw(cfg(m, 1'b1, W_FOUR, 4'h0));
      wait_stb();
      pat <= 12'h004;
      for (k = 1; k < 20; k++) begin
         wait_stb();
         if (pout[3:0] === 4'h5) break;
      end
   endtask
   initial begin
      #(40 * 20000);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      n = $urandom(32'h1258a947);
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      axi(0, OFS_CONFIG, 0);
      chk("config reset", CFG_RESET, rd);
      axi(0, 8'h3C, 0);
      chk("unmapped read resp", RESP_SLVERR, rs);
      chk("unmapped read data", 32'h0, rd);
      axi(1, 8'h3C, 32'h1);
      chk("unmapped write", RESP_SLVERR, rs);
      for (int w = 0; w < 32; w++) begin
         axi(1, OFS_CONFIG, cfg(3'd1, w[4], w[3:0], 4'h0));
         axi(0, OFS_STATUS, 0);
         chk("illegal flag", !ok_w(w[4], w[3:0]), rd[1]);
      end
      for (int i = 0; i < 8; i++) begin
         pat <= 12'($urandom);
         setw(cfg(3'd1, 1'b1, W_FOUR, {2'(i), i[2], 1'b0}));
         v = i[2] ? pat[11:8] : i[1] ? pat[7:4] : pat[3:0];
         chk("word", wexp(v, 1'b1), pout[3:0]);
         chk("cascade out", {3{v[0], v[2]}}, cout);
         chk("direct", i[2] ? pat[8] : i[0] ? pat[4] : pat[0], dout);
      end
      pat <= 12'h001;
      setw(cfg(3'd1, 1'b0, W_FOUR, 4'h0));
      chk("single rate", wexp(4'h1, 1'b0), pout[3:0]);
      // A low clock enable must hold the word although the pads change.
      ce <= 1'b0;
      pat <= 12'h000;
      repeat (32) @(posedge mclk);
      chk("frozen word", wexp(4'h1, 1'b0), pout[3:0]);
      ce <= 1'b1;
      pat <= 12'h001;
      setw(cfg(3'd2, 1'b1, W_FOUR, 4'h0));
      repeat (8) begin
         @(posedge mclk);
         chk("oversample strobe", 1, stb);
      end
      chk("oversample word", 8'h01, pout);
      for (int j = 0; j < 2; j++) begin
         casc <= 6'($urandom);
         setw(cfg(3'd1, 1'b1, j ? W_FOURTEEN : W_TEN, 4'h1));
         chk("slave low bits", 0, pout[1:0]);
         if (j) chk("slave 14", casc, pout[7:2]);
         else chk("slave 10", casc[1:0], pout[3:2]);
      end
      casc <= 6'h00;
      for (int m = 0; m < 5; m++) begin
         axi(1, OFS_CONFIG, cfg(3'(m), 1'b1, W_FOUR, 4'h0) | 32'h10000);
         // Polarity may only be flipped in the tool-only memory modes.
         if (m >= 3) begin
            fcis <= !fcis;
            wcis <= !wcis;
         end
         repeat (8) @(posedge mclk);
         axi(0, OFS_STATUS, 0);
         chk("suspect flag", m >= 3, rd[0]);
      end
      fcis <= 1'b0;
      lat(3'd0, nm);
      lat(3'd1, nn);
      chk("memory vs network latency", nm + 1, nn);
      lat(3'd3, n);
      chk("quad model latency", nn, n);
      lat(3'd4, n);
      chk("third gen latency", nn, n);
      tally_and_finish();
   end
endmodule
